// ===== mid_alu.sv
`timescale 1ns/10ps
module mid_alu (
  // Operation and operands
  input mid_pkg::mid_alu_op_e op,
  input logic [7:0] a,
  input logic [7:0] w,
  input logic cin,
  // Result with flags
  output mid_pkg::mid_alu_res_s res
);
  import mid_pkg::*;
  logic [8:0] sum;
  logic [4:0] nib;
  always_comb begin
    sum = 9'h000;
    nib = 5'h00;
    res = '0;
    unique case (op)
      ALU_ADD: begin
        sum = {1'b0, a} + {1'b0, w};
        nib = {1'b0, a[3:0]} + {1'b0, w[3:0]};
      end
      // Carry set means no borrow
      ALU_SUB: begin
        sum = {1'b0, a} + {1'b0, ~w} + 9'h001;
        nib = {1'b0, a[3:0]} + {1'b0, ~w[3:0]} + 5'h01;
      end
      ALU_AND: sum = {1'b0, a & w};
      ALU_OR: sum = {1'b0, a | w};
      ALU_XOR: sum = {1'b0, a ^ w};
      ALU_COM: sum = {1'b0, ~a};
      ALU_DEC: sum = {1'b0, a - 8'h01};
      ALU_INC: sum = {1'b0, a + 8'h01};
      ALU_RLC: sum = {a[7], a[6:0], cin};
      ALU_RRC: sum = {a[0], cin, a[7:1]};
      ALU_SWAP: sum = {1'b0, a[3:0], a[7:4]};
      ALU_PASS: sum = {1'b0, a};
    endcase
    res.res = sum[7:0];
    res.c = sum[8];
    res.dc = nib[4];
    res.z = (sum[7:0] == 8'h00);
  end
endmodule : mid_alu

// ===== mid_consts.svh
`ifndef MID_CONSTS_SVH
`define MID_CONSTS_SVH
// Widths and sizes
`define MID_PC_W 11
`define MID_STK_D 8
`define MID_STK_W 3
`define MID_OSC_PER_CYC 4
// Register-file addresses
`define MID_TIMER0_ADDR 7'h01
`define MID_PORT_ADDR 7'h06
// Instruction classes
`define MID_CL_BYTE 2'h0
`define MID_CL_BIT 2'h1
`define MID_CL_JUMP 2'h2
`define MID_CL_LIT 2'h3
// Byte opcodes
`define MID_OP_MISC 4'h0
`define MID_OP_CLR 4'h1
`define MID_OP_SUB 4'h2
`define MID_OP_DEC 4'h3
`define MID_OP_OR 4'h4
`define MID_OP_AND 4'h5
`define MID_OP_XOR 4'h6
`define MID_OP_ADD 4'h7
`define MID_OP_MOV 4'h8
`define MID_OP_COM 4'h9
`define MID_OP_INC 4'ha
`define MID_OP_DECSZ 4'hb
`define MID_OP_RRC 4'hc
`define MID_OP_RLC 4'hd
`define MID_OP_SWAP 4'he
`define MID_OP_INCSZ 4'hf
// Fixed control codes, low byte
`define MID_CODE_RET 8'h08
`define MID_CODE_RETI 8'h09
`define MID_CODE_SLEEP 8'h63
`define MID_CODE_WDCLR 8'h64
// APB map and reset values
`define MID_REG_CTRL 12'h000
`define MID_REG_STAT 12'h004
`define MID_REG_ACC 12'h008
`define MID_REG_PC 12'h00c
`define MID_CTRL_RST 1'b1
`endif

// ===== mid_core.sv
// Implementation choices: the address map and the APB interface to the registers.
`timescale 1ns/10ps
// Functional notes
// - instruction cycle is four clock periods
// - skips and jumps add one no-op cycle
// - top two bits select instruction class
// - byte add, sub, and, or, xor, complement
// - inc/dec, skip variants skip on zero
// - rotates go through carry, nine bits
// - flag updates depend on instruction type
// - bit clear, set, test-and-skip ops
// - call and jump to 11-bit address
// - returns pop stack, take two cycles
// - load, literal minus acc, literal plus acc
// - literal and, or, xor touch zero only
// - standby op enters sleep, updates flags
// - watchdog clear op clears counter, prescaler; core pulses watchdog_clear only, prescaler_clear stays low
// - watchdog clear sets timeout and power-down flags
// - port source value taken from pins
// - timer zero write clears its prescaler
// - destination bit picks accumulator or register
// - register operand is 7-bit address
`include "mid_consts.svh"
module mid_core (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Program memory
  output logic [`MID_PC_W-1:0] pm_addr,
  input wire logic [13:0] pm_data,
  // Register file
  output mid_pkg::mid_rf_req_s rf_req,
  input wire logic [7:0] rf_rdata,
  // Pins and peripherals
  input wire logic [7:0] port_pins,
  input wire logic wake,
  input wire logic prescaler_on_timer0,
  // Core status
  output mid_pkg::mid_flags_s flags,
  output logic standby,
  output logic watchdog_clear,
  output logic prescaler_clear,
  output logic interrupt_enable_set
);
  import mid_pkg::*;
  mid_state_s s_q;
  mid_state_s s_d;
  mid_alu_op_e alu_op;
  logic [7:0] alu_a;
  mid_alu_res_s alu_r;
  logic go;
  logic is_lit;
  function automatic mid_alu_op_e alu_sel(input logic [13:0] i);
    mid_alu_op_e o;
    o = ALU_PASS;
    if (i[13:12] == `MID_CL_BYTE) begin
      case (i[11:8])
        `MID_OP_ADD: o = ALU_ADD;
        `MID_OP_SUB: o = ALU_SUB;
        `MID_OP_AND: o = ALU_AND;
        `MID_OP_OR: o = ALU_OR;
        `MID_OP_XOR: o = ALU_XOR;
        `MID_OP_COM: o = ALU_COM;
        `MID_OP_DEC, `MID_OP_DECSZ: o = ALU_DEC;
        `MID_OP_INC, `MID_OP_INCSZ: o = ALU_INC;
        `MID_OP_RLC: o = ALU_RLC;
        `MID_OP_RRC: o = ALU_RRC;
        `MID_OP_SWAP: o = ALU_SWAP;
        default: o = ALU_PASS;
      endcase
    end else if (i[13:12] == `MID_CL_LIT) begin
      casez (i[11:8])
        4'b110?: o = ALU_SUB;
        4'b111?: o = ALU_ADD;
        4'b1001: o = ALU_AND;
        4'b1000: o = ALU_OR;
        4'b1010: o = ALU_XOR;
        default: o = ALU_PASS;
      endcase
    end
    return o;
  endfunction : alu_sel
  assign go = s_q.run && !s_q.standby;
  assign is_lit = (s_q.instr[13:12] == `MID_CL_LIT);
  assign alu_op = alu_sel(s_q.instr);
  assign alu_a = is_lit ? s_q.instr[7:0] : s_q.opnd;
  mid_alu u_alu (
    .op(alu_op),
    .a(alu_a),
    .w(s_q.acc),
    .cin(s_q.flags.carry),
    .res(alu_r)
  );
  always_comb begin
    logic [13:0] ins;
    logic [3:0] op;
    logic dst;
    logic wr_en;
    logic [7:0] wr_val;
    logic upd_c;
    logic upd_dc;
    logic upd_z;
    logic pop;
    logic [7:0] mask;
    logic [`MID_STK_W-1:0] sp_m1;
    ins = s_q.instr;
    op = ins[11:8];
    dst = ins[7];
    wr_en = 1'b0;
    wr_val = 8'h00;
    upd_c = 1'b0;
    upd_dc = 1'b0;
    upd_z = 1'b0;
    pop = 1'b0;
    mask = 8'h01 << ins[9:7];
    sp_m1 = s_q.sp - `MID_STK_W'(1);
    s_d = s_q;
    s_d.wdt_clr = 1'b0;
    s_d.gie_set = 1'b0;
    s_d.rf.we = 1'b0;
    // Pins cross into the clock domain first
    s_d.sync1 = {wake, port_pins};
    s_d.sync2 = s_q.sync1;
    if (s_q.standby && s_q.sync2[8]) s_d.standby = 1'b0;
    if (go) begin
      s_d.phase = mid_phase_e'(s_q.phase + 2'b01);
      unique case (s_q.phase)
        PH_Q1: ;
        // 7-bit operand address, kept through a no-op cycle
        PH_Q2: if (!s_q.skip) begin
          s_d.instr = pm_data;
          s_d.rf.addr = pm_data[6:0];
        end
        PH_Q3: s_d.opnd = (s_q.rf.addr == `MID_PORT_ADDR) ? s_q.sync2[7:0] : rf_rdata;
        PH_Q4: begin
          s_d.pc = s_q.pc + `MID_PC_W'(1);
          if (s_q.skip) begin
            s_d.skip = 1'b0;
            // A taken jump or return has already loaded its target
            if (ins[13:12] == `MID_CL_JUMP || (is_lit && op[3:2] == 2'b01) ||
                {ins[13:1], 1'b0} == {6'h00, `MID_CODE_RET}) s_d.pc = s_q.pc;
          end else begin
            unique case (ins[13:12])
              `MID_CL_BYTE: begin
                if (op == `MID_OP_MISC) begin
                  if (dst) begin
                    wr_en = 1'b1;
                    wr_val = s_q.acc;
                  end else begin
                    case (ins[7:0])
                      `MID_CODE_RET: pop = 1'b1;
                      `MID_CODE_RETI: begin
                        pop = 1'b1;
                        s_d.gie_set = 1'b1;
                      end
                      `MID_CODE_SLEEP: begin
                        s_d.standby = 1'b1;
                        s_d.flags.timeout_flag = 1'b1;
                        s_d.flags.power_down_flag = 1'b0;
                      end
                      `MID_CODE_WDCLR: begin
                        s_d.wdt_clr = 1'b1;
                        s_d.flags.timeout_flag = 1'b1;
                        s_d.flags.power_down_flag = 1'b1;
                      end
                      default: ;
                    endcase
                  end
                end else if (op == `MID_OP_CLR) begin
                  wr_en = dst;
                  if (!dst) s_d.acc = 8'h00;
                  s_d.flags.zero = 1'b1;
                end else begin
                  wr_en = dst;
                  wr_val = alu_r.res;
                  if (!dst) s_d.acc = alu_r.res;
                  unique case (op)
                    `MID_OP_ADD, `MID_OP_SUB: begin
                      upd_c = 1'b1;
                      upd_dc = 1'b1;
                      upd_z = 1'b1;
                    end
                    `MID_OP_RLC, `MID_OP_RRC: upd_c = 1'b1;
                    `MID_OP_SWAP: ;
                    `MID_OP_DECSZ, `MID_OP_INCSZ: s_d.skip = alu_r.z;
                    default: upd_z = 1'b1;
                  endcase
                end
              end
              `MID_CL_BIT: begin
                wr_en = !ins[11];
                unique case (ins[11:10])
                  2'b00: wr_val = s_q.opnd & ~mask;
                  2'b01: wr_val = s_q.opnd | mask;
                  2'b10: s_d.skip = ((s_q.opnd & mask) == 8'h00);
                  2'b11: s_d.skip = ((s_q.opnd & mask) != 8'h00);
                endcase
              end
              `MID_CL_JUMP: begin
                if (!ins[11]) begin
                  s_d.stack[s_q.sp] = s_q.pc + `MID_PC_W'(1);
                  s_d.sp = s_q.sp + `MID_STK_W'(1);
                end
                s_d.pc = ins[10:0];
                s_d.skip = 1'b1;
              end
              `MID_CL_LIT: begin
                if (op[3:2] == 2'b01) begin
                  s_d.acc = ins[7:0];
                  pop = 1'b1;
                end else begin
                  s_d.acc = alu_r.res;
                  upd_z = (op[3:2] != 2'b00);
                  upd_c = (op[3:2] == 2'b11);
                  upd_dc = upd_c;
                end
              end
            endcase
          end
          if (pop) begin
            s_d.sp = sp_m1;
            s_d.pc = s_q.stack[sp_m1];
            s_d.skip = 1'b1;
          end
          if (upd_c) s_d.flags.carry = alu_r.c;
          if (upd_dc) s_d.flags.half_carry_flag = alu_r.dc;
          if (upd_z) s_d.flags.zero = alu_r.z;
          s_d.rf.we = wr_en;
          s_d.rf.wdata = wr_val;
        end
      endcase
    end
    s_d.pre_clr = s_d.rf.we && (s_d.rf.addr == `MID_TIMER0_ADDR) && prescaler_on_timer0;
    // Registered answer, ready in the first access cycle, so no wait state
    s_d.pready = psel && !penable;
    s_d.pslverr = 1'b0;
    s_d.prdata = 32'h0000_0000;
    if (psel && !penable) begin
      case (paddr)
        `MID_REG_CTRL: s_d.prdata = {31'h0000_0000, s_q.run};
        `MID_REG_STAT: s_d.prdata = {25'h000_0000, s_q.standby, s_q.skip, s_q.flags};
        `MID_REG_ACC: s_d.prdata = {24'h00_0000, s_q.acc};
        `MID_REG_PC: s_d.prdata = {21'h00_0000, s_q.pc};
        default: s_d.pslverr = 1'b1;
      endcase
    end
    if (psel && penable && s_q.pready && pwrite && paddr == `MID_REG_CTRL) s_d.run = pwdata[0];
  end
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
      s_q.run <= `MID_CTRL_RST;
      s_q.flags.timeout_flag <= 1'b1;
      s_q.flags.power_down_flag <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end
  assign prdata = s_q.prdata;
  assign pready = s_q.pready;
  assign pslverr = s_q.pslverr;
  assign pm_addr = s_q.pc;
  assign rf_req = s_q.rf;
  assign flags = s_q.flags;
  assign standby = s_q.standby;
  assign watchdog_clear = s_q.wdt_clr;
  assign prescaler_clear = s_q.pre_clr;
  assign interrupt_enable_set = s_q.gie_set;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  sequence seq_exec;
    go && s_q.phase == PH_Q4 && !s_q.skip;
  endsequence
  sequence seq_wdclr;
    seq_exec ##0 s_q.instr == {6'h00, `MID_CODE_WDCLR};
  endsequence
  sequence seq_sleep;
    seq_exec ##0 s_q.instr == {6'h00, `MID_CODE_SLEEP};
  endsequence
  a_phase_step: assert property (go && s_q.phase == PH_Q1 |=> s_q.phase == PH_Q2)
    else $error("phase did not advance");
  a_jump_skip: assert property (seq_exec ##0 s_q.instr[13:12] == 2'b10
    |=> s_q.skip && s_q.pc == $past(s_q.instr[10:0]))
    else $error("jump target or no-op slot wrong");
  a_skip_nop: assert property (go && s_q.phase == PH_Q4 && s_q.skip
    |=> !s_q.skip && !s_q.rf.we && $stable(s_q.acc))
    else $error("no-op cycle had an effect");
  a_wdclr_flags: assert property (seq_wdclr
    |=> watchdog_clear && flags.timeout_flag && flags.power_down_flag)
    else $error("watchdog clear flags wrong");
  a_sleep_entry: assert property (seq_sleep
    |=> standby && !flags.power_down_flag && flags.timeout_flag)
    else $error("standby entry wrong");
  a_rotate_z: assert property (seq_exec ##0 s_q.instr[13:8] == {2'b00, `MID_OP_RLC}
    |=> $stable(s_q.flags.zero))
    else $error("rotate changed zero flag");
  a_decsz_skip: assert property (seq_exec ##0 s_q.instr[13:8] == {2'b00, `MID_OP_DECSZ}
    ##0 s_q.opnd == 8'h01 |=> s_q.skip)
    else $error("decrement to zero did not skip");
  a_dest_acc: assert property (seq_exec ##0 s_q.instr[13:12] == 2'b00 && !s_q.instr[7]
    && s_q.instr[11:9] != 3'b000 |=> !rf_req.we)
    else $error("register written with acc destination");
  a_apb_ready: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("APB answer timing wrong");
  a_target_kept: assert property (seq_exec ##0 s_q.instr[13:12] == 2'b10
    |-> ##5 s_q.pc == $past(s_q.instr[10:0], 5))
    else $error("no-op cycle after jump moved the counter");
endmodule : mid_core

// ===== mid_core_bench.sv
`timescale 1ns/10ps
`include "mid_consts.svh"
module mid_core_bench;
  import mid_pkg::*;
  typedef struct packed {
    logic [13:0] wd;
    logic [7:0] w;
    logic [7:0] rv;
    logic [7:0] acc;
    logic [4:0] st;
  } mid_case_s;
  logic ref_clk, rst, psel, penable, pwrite, wake, pre_t0, pready, pslverr, rerr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [`MID_PC_W-1:0] pm_addr;
  logic [13:0] pm_data;
  mid_rf_req_s rf_req;
  logic [7:0] rf_rdata, port_pins;
  mid_flags_s flags;
  logic standby, wd_clr, pre_clr, ie_set;
  int num_errors, check_count, n_pre, n_ie;
  // Flags as {carry, half carry, zero, timeout, power down}
  mid_case_s cases [19] = '{
    '{14'h0720, 8'h0F, 8'h01, 8'h10, 5'h0B}, '{14'h0220, 8'h10, 8'h10, 8'h00, 5'h1F},
    '{14'h0520, 8'hF0, 8'h0F, 8'h00, 5'h07}, '{14'h0420, 8'hF0, 8'h0F, 8'hFF, 5'h03},
    '{14'h0620, 8'hFF, 8'h0F, 8'hF0, 5'h03}, '{14'h0920, 8'h00, 8'h13, 8'hEC, 5'h03},
    '{14'h0320, 8'h00, 8'h01, 8'h00, 5'h07}, '{14'h0A20, 8'h00, 8'hFF, 8'h00, 5'h07},
    '{14'h0820, 8'h55, 8'h00, 8'h00, 5'h07}, '{14'h0D20, 8'h00, 8'h81, 8'h02, 5'h13},
    '{14'h0C20, 8'h00, 8'h01, 8'h00, 5'h13}, '{14'h0E20, 8'h00, 8'hA5, 8'h5A, 5'h03},
    '{14'h3E01, 8'h0F, 8'h00, 8'h10, 5'h0B}, '{14'h3C05, 8'h05, 8'h00, 8'h00, 5'h1F},
    '{14'h390F, 8'hF0, 8'h00, 8'h00, 5'h07}, '{14'h3800, 8'h00, 8'h00, 8'h00, 5'h07},
    '{14'h3A5A, 8'h5A, 8'h00, 8'h00, 5'h07}, '{14'h0103, 8'h55, 8'h00, 8'h00, 5'h07},
    '{14'h0F20, 8'h00, 8'hFF, 8'h00, 5'h03}};

  mid_core mid_core_inst (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pm_addr(pm_addr), .pm_data(pm_data), .rf_req(rf_req),
    .rf_rdata(rf_rdata), .port_pins(port_pins), .wake(wake), .prescaler_on_timer0(pre_t0),
    .flags(flags), .standby(standby), .watchdog_clear(wd_clr), .prescaler_clear(pre_clr),
    .interrupt_enable_set(ie_set));
  mid_mem_model mid_mem_model_inst (.ref_clk(ref_clk), .pm_addr(pm_addr), .pm_data(pm_data),
    .rf_req(rf_req), .rf_rdata(rf_rdata));

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    if (pre_clr === 1'b1) n_pre++;
    if (ie_set === 1'b1) n_ie++;
  end

  task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask : check

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int k;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge ref_clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge ref_clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    check("apb answer", 32'd1, 32'(k < 20));
  endtask : apb

  // Reset first so no register write of the old program lands late
  task automatic load_reset;
    rst <= 1'b1;
    @(posedge ref_clk);
    for (int i = 0; i < 2048; i++) mid_mem_model_inst.prog[i] = 14'h0000;
    for (int i = 0; i < 128; i++) mid_mem_model_inst.regs[i] = 8'h00;
    n_pre = 0;
    n_ie = 0;
    repeat (10) @(posedge ref_clk);
  endtask : load_reset

  task automatic go;
    @(posedge ref_clk);
    rst <= 1'b0;
  endtask : go

  task automatic test_alu;
    foreach (cases[i]) begin
      load_reset;
      mid_mem_model_inst.regs[32] = cases[i].rv;
      mid_mem_model_inst.prog[0] = 14'h3000 | {6'h00, cases[i].w};
      mid_mem_model_inst.prog[1] = cases[i].wd;
      mid_mem_model_inst.prog[2] = 14'h2802;
      go;
      repeat (40) @(posedge ref_clk);
      apb(1'b0, 12'h008, 32'h0000_0000);
      check("acc", 32'(cases[i].acc), rdat);
      apb(1'b0, 12'h004, 32'h0000_0000);
      check("flags", 32'(cases[i].st), 32'(rdat[4:0]));
      check("reg kept", 32'(cases[i].rv), 32'(mid_mem_model_inst.regs[32]));
    end
  endtask : test_alu

  task automatic test_flow;
    int n;
    load_reset;
    mid_mem_model_inst.regs[34] = 8'h01;
    mid_mem_model_inst.prog[0:8] = '{14'h3000, 14'h15A1, 14'h1DA1, 14'h3077, 14'h0BA2,
      14'h3066, 14'h2010, 14'h0064, 14'h2808};
    mid_mem_model_inst.prog[16] = 14'h3442;
    go;
    n = 0;
    do begin
      @(posedge ref_clk);
      #1;
      n++;
    end while (wd_clr !== 1'b1 && n < 200);
    check("clocks to wd clear", 32'd44, 32'(n));
    repeat (12) @(posedge ref_clk);
    apb(1'b0, 12'h008, 32'h0000_0000);
    check("ret literal", 32'h0000_0042, rdat);
    check("bit set", 32'h0000_0008, 32'(mid_mem_model_inst.regs[33]));
    check("dec to reg", 32'h0000_0000, 32'(mid_mem_model_inst.regs[34]));
    check("loop pc", 32'h0000_0008, 32'(pm_addr));
  endtask : test_flow

  task automatic test_standby;
    load_reset;
    mid_mem_model_inst.prog[0:2] = '{14'h0063, 14'h0064, 14'h2802};
    go;
    repeat (40) @(posedge ref_clk);
    check("standby", 32'd1, 32'(standby));
    check("to pd", 32'd2, 32'({flags.timeout_flag, flags.power_down_flag}));
    check("held pc", 32'd1, 32'(pm_addr));
    wake <= 1'b1;
    repeat (8) @(posedge ref_clk);
    wake <= 1'b0;
    repeat (40) @(posedge ref_clk);
    check("awake", 32'd0, 32'(standby));
    check("to pd set", 32'd3, 32'({flags.timeout_flag, flags.power_down_flag}));
  endtask : test_standby

  task automatic test_misc;
    load_reset;
    mid_mem_model_inst.regs[6] = 8'h3C;
    mid_mem_model_inst.prog[0:6] = '{14'h305A, 14'h0081, 14'h0806, 14'h0A86, 14'h2010,
      14'h2012, 14'h2806};
    mid_mem_model_inst.prog[16] = 14'h0009;
    mid_mem_model_inst.prog[18] = 14'h0008;
    go;
    repeat (80) @(posedge ref_clk);
    check("store acc", 32'h0000_005A, 32'(mid_mem_model_inst.regs[1]));
    check("prescaler clr", 32'd1, 32'(n_pre));
    apb(1'b0, 12'h008, 32'h0000_0000);
    check("port read", 32'h0000_00C3, rdat);
    check("port inc", 32'h0000_00C4, 32'(mid_mem_model_inst.regs[6]));
    check("int return", 32'd1, 32'(n_ie));
    check("after returns", 32'h0000_0006, 32'(pm_addr));
  endtask : test_misc

  task automatic test_apb;
    logic [31:0] p;
    load_reset;
    go;
    apb(1'b0, 12'h004, 32'h0000_0000);
    check("stat reset", 32'h0000_0003, rdat);
    apb(1'b0, 12'h000, 32'h0000_0000);
    check("ctrl reset", 32'h0000_0001, rdat);
    apb(1'b0, 12'h010, 32'h0000_0000);
    check("unmapped err", 32'd1, 32'(rerr));
    check("unmapped data", 32'h0000_0000, rdat);
    apb(1'b1, 12'h008, 32'h0000_00FF);
    apb(1'b0, 12'h008, 32'h0000_0000);
    check("acc read only", 32'h0000_0000, rdat);
    apb(1'b1, 12'h000, 32'h0000_0000);
    apb(1'b0, 12'h00C, 32'h0000_0000);
    p = rdat;
    repeat (20) @(posedge ref_clk);
    apb(1'b0, 12'h00C, 32'h0000_0000);
    check("pc frozen", p, rdat);
    apb(1'b1, 12'h000, 32'h0000_0001);
    repeat (20) @(posedge ref_clk);
    apb(1'b0, 12'h00C, 32'h0000_0000);
    check("pc runs", 32'd1, 32'(rdat !== p));
  endtask : test_apb

  task automatic finish_test;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : finish_test

  initial begin
    rst = 1'b1;
    {psel, penable, pwrite, wake, pre_t0} = 5'b00001;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    port_pins = 8'hC3;
    test_alu;
    test_flow;
    test_standby;
    test_misc;
    test_apb;
    finish_test;
  end
  // Whole run needs well under 3000 clocks
  initial begin
    #400_000;
    num_errors++;
    $display("watchdog expired");
    finish_test;
  end
endmodule : mid_core_bench

// ===== mid_mem_model.sv
`timescale 1ns/10ps
`include "mid_consts.svh"
module mid_mem_model (
  // Clock
  input wire logic ref_clk,
  // Program memory side
  input wire logic [`MID_PC_W-1:0] pm_addr,
  output logic [13:0] pm_data,
  // Register file side
  input wire mid_pkg::mid_rf_req_s rf_req,
  output logic [7:0] rf_rdata
);
  import mid_pkg::*;
  logic [13:0] prog [0:2047];
  logic [7:0] regs [0:127];
  // Reads are combinational; the core samples them a phase later
  assign pm_data = prog[pm_addr];
  assign rf_rdata = regs[rf_req.addr];
  always @(posedge ref_clk) begin
    if (rf_req.we === 1'b1) begin
      regs[rf_req.addr] <= rf_req.wdata;
    end
  end
endmodule : mid_mem_model

// ===== mid_pkg.sv
`include "mid_consts.svh"
package mid_pkg;
  typedef enum logic [1:0] {
    PH_Q1 = 2'b00,
    PH_Q2 = 2'b01,
    PH_Q3 = 2'b10,
    PH_Q4 = 2'b11
  } mid_phase_e;
  typedef enum logic [3:0] {
    ALU_PASS = 4'b0000,
    ALU_ADD = 4'b0001,
    ALU_SUB = 4'b0010,
    ALU_AND = 4'b0011,
    ALU_OR = 4'b0100,
    ALU_XOR = 4'b0101,
    ALU_COM = 4'b0110,
    ALU_DEC = 4'b0111,
    ALU_INC = 4'b1000,
    ALU_RLC = 4'b1001,
    ALU_RRC = 4'b1010,
    ALU_SWAP = 4'b1011
  } mid_alu_op_e;
  typedef struct packed {
    logic [7:0] res;
    logic c;
    logic dc;
    logic z;
  } mid_alu_res_s;
  typedef struct packed {
    logic [6:0] addr;
    logic [7:0] wdata;
    logic we;
  } mid_rf_req_s;
  typedef struct packed {
    logic carry;
    logic half_carry_flag;
    logic zero;
    logic timeout_flag;
    logic power_down_flag;
  } mid_flags_s;
  typedef struct packed {
    mid_phase_e phase;
    logic [`MID_PC_W-1:0] pc;
    logic [13:0] instr;
    logic [7:0] opnd;
    logic [7:0] acc;
    mid_flags_s flags;
    logic skip;
    logic standby;
    logic run;
    logic gie_set;
    logic wdt_clr;
    logic pre_clr;
    logic [`MID_STK_D-1:0][`MID_PC_W-1:0] stack;
    logic [`MID_STK_W-1:0] sp;
    mid_rf_req_s rf;
    logic [8:0] sync1;
    logic [8:0] sync2;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } mid_state_s;
endpackage : mid_pkg
